// *** design/alt_counter_defines.vh ***
// Register map, field positions, reset values and mode codes of the alternating counter pair.
`ifndef ALT_COUNTER_DEFINES_VH
`define ALT_COUNTER_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_SHORT_CTRL      4'h0
`define IDX_SHARED_CFG      4'h1
`define IDX_LONG_CTRL       4'h2
`define IDX_SHORT_LOW_HOLD  4'h4
`define IDX_SHORT_HIGH_HOLD 4'h5
`define IDX_LONG_HOLD_LOWER 4'h6
`define IDX_LONG_HOLD_UPPER 4'h7
`define IDX_IRQ_STATUS      4'h8
`define IDX_IRQ_MASK        4'h9

// Counter control register fields, same layout for both counters.
`define CTRL_ENABLE_BIT     7
`define CTRL_SINGLE_BIT     6
`define CTRL_TIMEOUT_BIT    5
`define CTRL_PRESC_HI       4
`define CTRL_PRESC_LO       3
`define CTRL_INT_EN_BIT     1

// Shared configuration register fields.
`define CFG_DEMOD_BIT       6
`define CFG_MODE_HI         3
`define CFG_MODE_LO         2
`define CFG_SHORT_INIT_BIT  1
`define CFG_LONG_INIT_BIT   0
`define CFG_MODE_OFF        2'h0
`define CFG_MODE_ALTERNATE  2'h1

// Interrupt status and mask bit positions.
`define IRQ_SHORT_BIT       0
`define IRQ_LONG_BIT        1

// Reset values.
`define RST_CTRL            8'h00
`define RST_CFG             8'h00
`define RST_HOLD            8'h00
`define RST_IRQ             2'h0

`endif

// *** design/tc_down_counter.v ***
// Prescaled down counter that stops at zero and flags its terminal count.
`timescale 1ns/1ps
module tc_down_counter (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        load_i,
   input  wire        run_i,
   input  wire [15:0] value_i,
   input  wire [1:0]  prescale_i,
   output reg  [15:0] count_o,
   output reg         tc_o
);

   reg  [2:0] div_q;
   reg        done_q;
   wire [2:0] div_mask;
   wire       tick;

   assign div_mask = (prescale_i == 2'h0) ? 3'h0 :
                     (prescale_i == 2'h1) ? 3'h1 :
                     (prescale_i == 2'h2) ? 3'h3 : 3'h7;
   assign tick     = run_i && !done_q && ((div_q & div_mask) == div_mask);

   // The counter holds at zero after its terminal count, so a counter that the
   // sequencer is about to stop can never report a second terminal count.
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= 16'h0000;
         div_q   <= 3'h0;
         done_q  <= 1'b0;
         tc_o    <= 1'b0;
      end else if (ce_i) begin
         tc_o <= 1'b0;
         if (load_i) begin
            count_o <= value_i;
            div_q   <= 3'h0;
            done_q  <= 1'b0;
         end else if (run_i && !done_q) begin
            div_q <= div_q + 3'h1;
            if (tick) begin
               if (count_o > 16'h0001) begin
                  count_o <= count_o - 16'h0001;
               end else begin
                  count_o <= 16'h0000;
                  done_q  <= 1'b1;
                  tc_o    <= 1'b1;
               end
            end
         end
      end
   end

endmodule

// *** design/alt_counter_seq.v ***
// Alternating short/long counter sequencer with a classic Wishbone register slave.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "alt_counter_defines.vh"
module alt_counter_seq (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [5:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   output reg         short_counter_output_o,
   output reg         long_counter_output_o,
   output reg         irq_o
);

   reg  [7:0]  short_ctrl_q;
   reg  [7:0]  long_ctrl_q;
   reg  [7:0]  cfg_q;
   reg  [7:0]  short_low_hold_q;
   reg  [7:0]  short_high_hold_q;
   reg  [7:0]  long_hold_lower_q;
   reg  [7:0]  long_hold_upper_q;
   reg  [1:0]  irq_status_q;
   reg  [1:0]  irq_mask_q;
   reg         short_en_q;
   reg         long_en_q;
   reg         short_to_q;
   reg         long_to_q;
   reg         short_load_q;
   reg         long_load_q;
   reg  [31:0] rd_d;

   wire [15:0] short_count;
   wire [15:0] long_count;
   wire        short_tc;
   wire        long_tc;
   wire [3:0]  idx;
   wire        req;
   wire        acc;
   wire        wr;
   wire        transmit;
   wire        alternate;
   wire [15:0] short_value;
   wire [15:0] long_value;
   wire [1:0]  irq_set;

   assign idx       = adr_i[5:2];
   assign req       = cyc_i && stb_i && (adr_i[1:0] == 2'h0);
   assign acc       = cyc_i && stb_i && ack_o;
   assign wr        = acc && we_i && sel_i[0] && (adr_i[1:0] == 2'h0);
   assign transmit  = !cfg_q[`CFG_DEMOD_BIT];
   assign alternate = transmit && (cfg_q[`CFG_MODE_HI:`CFG_MODE_LO] == `CFG_MODE_ALTERNATE);

   // The hold value is picked from the output level that is already in place.
   assign short_value = {8'h00, short_counter_output_o ? short_high_hold_q : short_low_hold_q};
   assign long_value  = {long_hold_upper_q, long_hold_lower_q};

   assign irq_set[`IRQ_SHORT_BIT] = short_tc && short_ctrl_q[`CTRL_INT_EN_BIT];
   assign irq_set[`IRQ_LONG_BIT]  = long_tc && long_ctrl_q[`CTRL_INT_EN_BIT];

   tc_down_counter u_short (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .load_i     (short_load_q),
      .run_i      (short_en_q && !short_load_q),
      .value_i    (short_value),
      .prescale_i (short_ctrl_q[`CTRL_PRESC_HI:`CTRL_PRESC_LO]),
      .count_o    (short_count),
      .tc_o       (short_tc)
   );

   tc_down_counter u_long (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .load_i     (long_load_q),
      .run_i      (long_en_q && !long_load_q),
      .value_i    (long_value),
      .prescale_i (long_ctrl_q[`CTRL_PRESC_HI:`CTRL_PRESC_LO]),
      .count_o    (long_count),
      .tc_o       (long_tc)
   );

   always @* begin
      rd_d = 32'h00000000;
      case (idx)
         `IDX_SHORT_CTRL: begin
            rd_d[7:0] = {short_en_q, short_ctrl_q[6], short_to_q, short_ctrl_q[4:0]};
         end
         `IDX_SHARED_CFG: begin
            rd_d[7:0] = cfg_q;
         end
         `IDX_LONG_CTRL: begin
            rd_d[7:0] = {long_en_q, long_ctrl_q[6], long_to_q, long_ctrl_q[4:0]};
         end
         `IDX_SHORT_LOW_HOLD: begin
            rd_d[7:0] = short_low_hold_q;
         end
         `IDX_SHORT_HIGH_HOLD: begin
            rd_d[7:0] = short_high_hold_q;
         end
         `IDX_LONG_HOLD_LOWER: begin
            rd_d[7:0] = long_hold_lower_q;
         end
         `IDX_LONG_HOLD_UPPER: begin
            rd_d[7:0] = long_hold_upper_q;
         end
         `IDX_IRQ_STATUS: begin
            rd_d[1:0] = irq_status_q;
         end
         `IDX_IRQ_MASK: begin
            rd_d[1:0] = irq_mask_q;
         end
         default: begin
            rd_d = 32'h00000000;
         end
      endcase
   end

   // Bus answer: ack one cycle after the request, dropped the cycle after.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else if (ce_i) begin
         ack_o <= req && !ack_o;
         if (req && !ack_o && !we_i) begin
            dat_o <= rd_d;
         end
      end
   end

   // Configuration and hold registers; writes take effect on the acknowledged edge.
   always @(posedge clk_i) begin
      if (rst_i) begin
         short_ctrl_q      <= `RST_CTRL;
         long_ctrl_q       <= `RST_CTRL;
         cfg_q             <= `RST_CFG;
         short_low_hold_q  <= `RST_HOLD;
         short_high_hold_q <= `RST_HOLD;
         long_hold_lower_q <= `RST_HOLD;
         long_hold_upper_q <= `RST_HOLD;
         irq_mask_q        <= `RST_IRQ;
      end else if (ce_i && wr) begin
         case (idx)
            `IDX_SHORT_CTRL: begin
               short_ctrl_q <= dat_i[7:0];
            end
            `IDX_SHARED_CFG: begin
               cfg_q <= dat_i[7:0];
            end
            `IDX_LONG_CTRL: begin
               long_ctrl_q <= dat_i[7:0];
            end
            `IDX_SHORT_LOW_HOLD: begin
               short_low_hold_q <= dat_i[7:0];
            end
            `IDX_SHORT_HIGH_HOLD: begin
               short_high_hold_q <= dat_i[7:0];
            end
            `IDX_LONG_HOLD_LOWER: begin
               long_hold_lower_q <= dat_i[7:0];
            end
            `IDX_LONG_HOLD_UPPER: begin
               long_hold_upper_q <= dat_i[7:0];
            end
            `IDX_IRQ_MASK: begin
               irq_mask_q <= dat_i[1:0];
            end
            default: begin
               irq_mask_q <= irq_mask_q;
            end
         endcase
      end
   end

   // Sticky flags: a terminal count in the same cycle as a clear keeps the flag set.
   always @(posedge clk_i) begin
      if (rst_i) begin
         short_to_q   <= 1'b0;
         long_to_q    <= 1'b0;
         irq_status_q <= `RST_IRQ;
         irq_o        <= 1'b0;
      end else if (ce_i) begin
         if (wr && idx == `IDX_SHORT_CTRL && dat_i[`CTRL_TIMEOUT_BIT]) begin
            short_to_q <= 1'b0;
         end
         if (short_tc) begin
            short_to_q <= 1'b1;
         end
         if (wr && idx == `IDX_LONG_CTRL && dat_i[`CTRL_TIMEOUT_BIT]) begin
            long_to_q <= 1'b0;
         end
         if (long_tc) begin
            long_to_q <= 1'b1;
         end
         // Only the bits that the read returned are cleared. An event that lands
         // between the data capture and the acknowledge would otherwise be lost.
         if (acc && !we_i && idx == `IDX_IRQ_STATUS) begin
            irq_status_q <= (irq_status_q & ~dat_o[1:0]) | irq_set;
         end else begin
            irq_status_q <= irq_status_q | irq_set;
         end
         irq_o <= |((irq_status_q | irq_set) & irq_mask_q);
      end
   end

   // Sequencer. Software starts a counter by setting its enable; hardware handover
   // is written last so that it wins over a simultaneous software write, which keeps
   // that write from leaving both counters running at once in alternate mode.
   always @(posedge clk_i) begin
      if (rst_i) begin
         short_en_q             <= 1'b0;
         long_en_q              <= 1'b0;
         short_load_q           <= 1'b0;
         long_load_q            <= 1'b0;
         short_counter_output_o <= 1'b1;
         long_counter_output_o  <= 1'b0;
      end else if (ce_i) begin
         short_load_q <= 1'b0;
         long_load_q  <= 1'b0;
         if (!short_en_q && !alternate) begin
            short_counter_output_o <= !cfg_q[`CFG_SHORT_INIT_BIT];
         end
         // In alternate mode a software enable of the idle counter is refused while
         // the other one runs, so in this mode both count only if both were enabled before the mode was set.
         if (wr && idx == `IDX_SHORT_CTRL) begin
            short_en_q <= dat_i[`CTRL_ENABLE_BIT] && !(alternate && long_en_q);
            if (dat_i[`CTRL_ENABLE_BIT] && !short_en_q && !(alternate && long_en_q)) begin
               short_counter_output_o <= cfg_q[`CFG_SHORT_INIT_BIT];
               short_load_q           <= 1'b1;
            end
         end
         if (wr && idx == `IDX_LONG_CTRL) begin
            long_en_q <= dat_i[`CTRL_ENABLE_BIT] && !(alternate && short_en_q);
            if (dat_i[`CTRL_ENABLE_BIT] && !long_en_q && !(alternate && short_en_q)) begin
               long_counter_output_o <= cfg_q[`CFG_LONG_INIT_BIT];
               long_load_q           <= 1'b1;
            end
         end
         if (short_tc) begin
            short_counter_output_o <= !short_counter_output_o;
            if (alternate) begin
               short_en_q            <= 1'b0;
               long_en_q             <= 1'b1;
               long_counter_output_o <= cfg_q[`CFG_LONG_INIT_BIT];
               long_load_q           <= 1'b1;
            end else if (short_ctrl_q[`CTRL_SINGLE_BIT]) begin
               short_en_q <= 1'b0;
            end else begin
               short_load_q <= 1'b1;
            end
         end
         if (long_tc) begin
            if (alternate) begin
               long_en_q              <= 1'b0;
               short_en_q             <= 1'b1;
               short_counter_output_o <= cfg_q[`CFG_SHORT_INIT_BIT];
               short_load_q           <= 1'b1;
            end else if (long_ctrl_q[`CTRL_SINGLE_BIT]) begin
               long_en_q             <= 1'b0;
               long_counter_output_o <= !long_counter_output_o;
            end else begin
               long_counter_output_o <= !long_counter_output_o;
               long_load_q           <= 1'b1;
            end
         end
      end
   end

endmodule

// *** sim/alt_counter_seq_sva.sv ***
// Bus and pin assertions for the alternating counter sequencer.
`timescale 1ns/1ps
module alt_counter_seq_sva (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [5:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        short_counter_output_o,
   input wire logic        long_counter_output_o,
   input wire logic        irq_o
);
   logic [1:0] mask_q;
   logic [7:0] cfg_q;
   logic       wr;
   assign wr = ack_o && we_i && sel_i[0] && ce_i;
   // Shadow copies of mask and configuration, taken at the write's ack edge.
   always @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= 2'h0;
         cfg_q <= 8'h00;
      end else begin
         if (wr && adr_i[5:2] == 4'h9) mask_q <= dat_i[1:0];
         if (wr && adr_i[5:2] == 4'h1) cfg_q <= dat_i[7:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_PULSE: assert property (ack_o && ce_i |=> !ack_o) else $error("ack longer than one cycle");
   AST_ACK_TAKEN: assert property (ack_o |-> $past(cyc_i && stb_i && adr_i[1:0] == 2'h0))
      else $error("ack without request");
   AST_ACK_ANSWER: assert property (cyc_i && stb_i && adr_i[1:0] == 2'h0 && !ack_o && ce_i
      |=> ack_o) else $error("request not answered next cycle");
   AST_READ_UPPER: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_CE_FREEZE: assert property (!ce_i |=> $stable(ack_o) && $stable(irq_o) &&
      $stable(short_counter_output_o) && $stable(long_counter_output_o)) else $error("moved while frozen");
   AST_RESET_PINS: assert property ($fell(rst_i) |-> short_counter_output_o &&
      !long_counter_output_o && !irq_o && !ack_o) else $error("bad levels after reset");
   AST_IRQ_MASKED: assert property (irq_o && $past(ce_i) |-> $past(mask_q) != 2'h0)
      else $error("interrupt while fully masked");
   AST_SHORT_INIT: assert property (wr && adr_i[5:2] == 4'h0 && dat_i[7] && cfg_q[3:2] == 2'h1
      && !cfg_q[6] |=> short_counter_output_o == cfg_q[1]) else $error("short initial level wrong");
endmodule
bind alt_counter_seq alt_counter_seq_sva i_alt_counter_seq_sva (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .short_counter_output_o(short_counter_output_o),
   .long_counter_output_o(long_counter_output_o), .irq_o(irq_o));

// *** sim/alt_counter_seq_bench.sv ***
// Self-checking bench for the alternating counter sequencer.
`timescale 1ns/1ps
module alt_counter_seq_bench;
   logic        clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [5:0]  adr_i = 6'h00;
   logic [3:0]  sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, rd, rng = 32'h0001_6CDA;
   logic        ack_o, short_out, long_out, irq_o, s;
   logic [7:0]  cfg, v;
   int          n_mismatch = 0, comparisons = 0, cycles = 0;
   alt_counter_seq i_alt_counter_seq (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .short_counter_output_o(short_out), .long_counter_output_o(long_out),
      .irq_o(irq_o));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] a);
      logic [31:0] t;
      t = a ^ (a << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // The run is well under a thousand cycles; the ceiling only catches a dead bus.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_pin(input logic l, input logic val, input int lim);
      for (int k = 0; k < lim && (l ? long_out : short_out) !== val; k++) @(posedge clk_i);
      check({31'h0, l ? long_out : short_out}, {31'h0, val});
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({30'h0, short_out, long_out}, 32'h2);
      for (int i = 0; i < 10; i++) begin
         wb(1'b0, i[3:0], 8'h00);
         check(rd, 32'h0);
      end
      // Index 3 is unmapped, so its write must vanish.
      for (int i = 3; i < 8; i++) begin
         rng = xs(rng);
         wb(1'b1, i[3:0], rng[7:0]);
         wb(1'b0, i[3:0], 8'h00);
         check(rd, (i == 3) ? 32'h0 : {24'h0, rng[7:0]});
      end
      wb(1'b1, 4'h1, 8'h02);
      wait_pin(1'b0, 1'b0, 4);
      wb(1'b1, 4'h4, 8'h40);
      wb(1'b1, 4'h5, 8'h08);
      wb(1'b1, 4'h6, 8'h30);
      wb(1'b1, 4'h7, 8'h00);
      wb(1'b1, 4'h9, 8'h01);
      for (int j = 0; j < 2; j++) begin
         rng = xs(rng);
         cfg = {6'h01, (j == 0) ? 2'h3 : rng[1:0]};
         s = cfg[1];
         wb(1'b1, 4'h2, 8'h00);
         wb(1'b1, 4'h0, 8'h00);
         wb(1'b0, 4'h8, 8'h00);
         wb(1'b1, 4'h1, cfg);
         wb(1'b1, 4'h2, (j == 0) ? 8'h42 : 8'h40);
         wb(1'b1, 4'h0, 8'hC2);
         check({31'h0, short_out}, {31'h0, s});
         wait_pin(1'b0, !s, s ? 14 : 80);
         check({31'h0, long_out}, {31'h0, cfg[0]});
         wb(1'b0, 4'h0, 8'h00);
         check(rd & 32'h80, 32'h0);
         wb(1'b0, 4'h2, 8'h00);
         check(rd & 32'h80, 32'h80);
         check({31'h0, irq_o}, 32'h1);
         ce_i <= 1'b0;
         repeat (3) @(posedge clk_i);
         ce_i <= 1'b1;
         wait_pin(1'b0, s, 90);
         wb(1'b0, 4'h8, 8'h00);
         check(rd, (j == 0) ? 32'h3 : 32'h1);
         wb(1'b1, 4'h1, cfg & 8'hF3);
         repeat (150) @(posedge clk_i);
         wb(1'b0, 4'h2, 8'h00);
         check(rd & 32'h80, 32'h0);
      end
      end_of_test();
   end
endmodule
